/* inc/cic_link_if.sv */
/*
 Link between the CIC interpolator chain and its feeding, configuring party.
 Assumes both ends run on the same clock and reset, passed as module ports.
*/
`timescale 1ns/1ps
interface cic_link_if;
    import cic_pkg::*;
    logic cfg_wr;
    logic [ADDR_W-1:0] cfg_addr;
    logic [DATA_W-1:0] cfg_data;
    logic smp_ready;
    logic smp_valid;
    logic [IN_W-1:0] smp_data;

    modport dev (
        input cfg_wr, cfg_addr, cfg_data, smp_valid, smp_data,
        output smp_ready
    );
    modport fir (
        output cfg_wr, cfg_addr, cfg_data, smp_valid, smp_data,
        input smp_ready
    );
endinterface : cic_link_if

/* inc/cic_pkg.sv */
/*
 Shared constants and scale decoders for the two-stage CIC interpolator
 chain and the party that feeds and configures it.
 Assumes one system clock shared by both ends.
*/
package cic_pkg;
    // ============================================================
    // Widths
    localparam int IN_W = 13;
    localparam int S1_ACC_W = 28;
    localparam int S1_OUT_W = 13;
    localparam int S1_ORDER = 4;
    localparam int S2_ACC_W = 25;
    localparam int S2_OUT_W = 10;
    localparam int S2_ORDER = 3;
    localparam int SC1_W = 5;
    localparam int SC2_W = 6;
    localparam int R1_W = 6;
    localparam int R2_W = 7;
    localparam int MSB_W = 5;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int COEF_W = 10;
    localparam int COEF_FRAC = 9;
    localparam int GAIN_W = 40;

    // ============================================================
    // Limits, offsets, reset values
    localparam logic [R1_W-1:0] R1_MAX = 6'h20;
    localparam logic [R2_W-1:0] R2_MAX = 7'h40;
    localparam logic [MSB_W-1:0] BASE_MSB = 5'h0C;
    localparam logic [ADDR_W-1:0] ADDR_SCALE1 = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_SCALE2 = 8'h15;
    localparam logic [ADDR_W-1:0] ADDR_RATE1 = 8'h16;
    localparam logic [ADDR_W-1:0] ADDR_RATE2 = 8'h17;
    localparam logic [R1_W-1:0] RST_RATE1 = 6'h04;
    localparam logic [SC1_W-1:0] RST_SCALE1 = 5'h03;
    localparam logic [R2_W-1:0] RST_RATE2 = 7'h04;
    localparam logic [SC2_W-1:0] RST_SCALE2 = 6'h03;
    localparam logic [COEF_W-1:0] RST_COEF = 10'h1FF;

    // ============================================================
    // Scale word to top bit of the passed group, first stage
    function automatic logic [MSB_W-1:0] msb1(input logic [SC1_W-1:0] s);
        if (s >= 5'h1F) return 5'h1B;
        if (s >= 5'h19) return 5'h1A;
        if (s >= 5'h14) return 5'h19;
        if (s >= 5'h0F) return 5'h18;
        if (s >= 5'h0C) return 5'h17;
        if (s >= 5'h0A) return 5'h16;
        if (s >= 5'h07) return 5'h15;
        if (s >= 5'h06) return 5'h14;
        if (s >= 5'h05) return 5'h13;
        if (s >= 5'h03) return 5'h12;
        if (s >= 5'h02) return 5'h10;
        if (s >= 5'h01) return 5'h0F;
        return 5'h0C;
    endfunction : msb1

    // Scale word to top bit of the passed group, second stage
    function automatic logic [MSB_W-1:0] msb2(input logic [SC2_W-1:0] s);
        if (s >= 6'h3F) return 5'h18;
        if (s >= 6'h2D) return 5'h17;
        if (s >= 6'h1F) return 5'h16;
        if (s >= 6'h16) return 5'h15;
        if (s >= 6'h0F) return 5'h14;
        if (s >= 6'h0B) return 5'h13;
        if (s >= 6'h07) return 5'h12;
        if (s >= 6'h05) return 5'h11;
        if (s >= 6'h03) return 5'h10;
        if (s >= 6'h02) return 5'h0F;
        if (s >= 6'h01) return 5'h0E;
        return 5'h0C;
    endfunction : msb2

    // Smallest word whose group sits one step higher; divides the gain by 2 for each bit the group top rises
    function automatic logic [SC1_W-1:0] alt1(input logic [SC1_W-1:0] s);
        logic [SC1_W-1:0] r;
        r = s;
        for (int v = 31; v >= 0; v--) begin
            if (msb1(SC1_W'(v)) > msb1(s)) r = SC1_W'(v);
        end
        return r;
    endfunction : alt1

    function automatic logic [SC2_W-1:0] alt2(input logic [SC2_W-1:0] s);
        logic [SC2_W-1:0] r;
        r = s;
        for (int v = 63; v >= 0; v--) begin
            if (msb2(SC2_W'(v)) > msb2(s)) r = SC2_W'(v);
        end
        return r;
    endfunction : alt2
endpackage : cic_pkg

/* verif/cic_link_properties.sv */
/*
 Concurrent checks on the CIC link and on the chain's lock outputs.
 Assumes one clock and an async active-low reset; instantiated by the bench.
*/
`timescale 1ns/1ps
module cic_link_properties
    import cic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cfg_wr,
    input wire logic [ADDR_W-1:0] cfg_addr,
    input wire logic [DATA_W-1:0] cfg_data,
    input wire logic smp_ready,
    input wire logic smp_valid,
    input wire logic [IN_W-1:0] smp_data,
    input wire logic iq_valid,
    input wire logic ovf_lock
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ============================================================
    // Configuration walk
    sequence wr_at(logic [ADDR_W-1:0] a);
        cfg_wr && cfg_addr == a;
    endsequence
    sequence walk_tail;
        wr_at(ADDR_SCALE2) ##1 wr_at(ADDR_RATE1) ##1 wr_at(ADDR_RATE2) ##1 !cfg_wr;
    endsequence

    cfg_walk_a: assert property (wr_at(ADDR_SCALE1) |=> walk_tail)
        else $error("config writes out of order");
    cfg_start_a: assert property ($rose(cfg_wr) |-> wr_at(ADDR_SCALE1))
        else $error("config walk not started at first scale word");
    cfg_addr_a: assert property (cfg_wr |-> cfg_addr inside {[ADDR_SCALE1:ADDR_RATE2]})
        else $error("config write to unexpected address");

    // ============================================================
    // Sample stream and lock
    smp_hold_a: assert property (smp_valid && !smp_ready |=> smp_valid && $stable(smp_data))
        else $error("sample dropped before it was taken");
    lock_hold_a: assert property (ovf_lock |=> ovf_lock)
        else $error("overflow lock cleared without reset");
    lock_ready_a: assert property (ovf_lock |-> !smp_ready)
        else $error("sample requested while locked");
    lock_valid_a: assert property (ovf_lock |=> !iq_valid)
        else $error("output valid while locked");
    run_valid_a: assert property (!ovf_lock ##1 !ovf_lock |-> iq_valid)
        else $error("output not valid while running");
endmodule : cic_link_properties

/* verif/testbench.sv */
/*
 Self-checking bench: host and chain joined by one link, plus a second
 chain driven raw by the bench to force the overflow lock.
 Assumes the package decoders stay unused here; expectations are own.
*/
`timescale 1ns/1ps
module testbench;
    import cic_pkg::*;
    localparam int B1[13] = '{0, 1, 2, 3, 5, 6, 7, 10, 12, 15, 20, 25, 31};
    localparam int M1[13] = '{12, 15, 16, 18, 19, 20, 21, 22, 23, 24, 25, 26, 27};
    localparam int B2[13] = '{0, 1, 2, 3, 5, 7, 11, 15, 22, 31, 45, 63, 999};
    localparam int M2[13] = '{12, 14, 15, 16, 17, 18, 19, 20, 21, 22, 23, 24, 24};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rst2_n = 1'b0;
    logic usr_cfg = 1'b0;
    logic usr_alt1 = 1'b0;
    logic usr_alt2 = 1'b0;
    logic usr_valid = 1'b0;
    logic [R1_W-1:0] usr_rate1 = '0;
    logic [R2_W-1:0] usr_rate2 = '0;
    logic [COEF_W-1:0] usr_coef = '0;
    logic [IN_W-1:0] usr_data = '0;
    logic cfg_busy, cfg_refused, usr_ready, iq_valid, ovf_lock, iqv2, lock2;
    logic [S2_OUT_W-1:0] iq_data, iq2;
    logic [DATA_W-1:0] seen [4];
    logic [31:0] seed = 32'hD5C7A181;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;

    cic_link_if lnk();
    cic_link_if lnk2();
    cic_chain_dev u_cic_chain_dev (.clk(clk), .rst_n(rst_n), .lnk(lnk), .iq_data(iq_data),
        .iq_valid(iq_valid), .ovf_lock(ovf_lock));
    cic_feed_host u_cic_feed_host (.clk(clk), .rst_n(rst_n), .lnk(lnk), .usr_cfg(usr_cfg),
        .usr_rate1(usr_rate1), .usr_rate2(usr_rate2), .usr_alt1(usr_alt1),
        .usr_alt2(usr_alt2), .usr_coef(usr_coef), .cfg_busy(cfg_busy),
        .cfg_refused(cfg_refused), .usr_valid(usr_valid), .usr_data(usr_data),
        .usr_ready(usr_ready));
    // Second chain is fed raw so a gain breach can be forced
    cic_chain_dev u_cic_chain_dev2 (.clk(clk), .rst_n(rst2_n), .lnk(lnk2), .iq_data(iq2),
        .iq_valid(iqv2), .ovf_lock(lock2));
    cic_link_properties u_props (.clk(clk), .rst_n(rst_n), .cfg_wr(lnk.cfg_wr),
        .cfg_addr(lnk.cfg_addr), .cfg_data(lnk.cfg_data), .smp_ready(lnk.smp_ready),
        .smp_valid(lnk.smp_valid), .smp_data(lnk.smp_data), .iq_valid(iq_valid),
        .ovf_lock(ovf_lock));

    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        if (lnk.cfg_wr && lnk.cfg_addr inside {[ADDR_SCALE1:ADDR_RATE2]}) begin
            seen[lnk.cfg_addr[1:0]] <= lnk.cfg_data;
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            wrap_up();
        end
    end

    // ============================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic int top(input int st, input int s);
        int t = 12;
        for (int i = 0; i < 13; i++) begin
            if (st == 1 && s >= B1[i]) t = M1[i];
            if (st == 2 && s >= B2[i]) t = M2[i];
        end
        return t;
    endfunction : top

    function automatic int alt(input int st, input int s);
        int r = s;
        for (int v = (st == 1 ? 31 : 63); v >= 0; v--) begin
            if (top(st, v) > top(st, s)) r = v;
        end
        return r;
    endfunction : alt

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // ============================================================
    // One configuration from reset, then a DC level through the chain
    task automatic run(input int r1, input int r2, input bit a1, input bit a2, input int cf,
        input int x);
        int w1, w2, s1, s2, ok, x1, e, y, lk;
        w1 = a1 ? alt(1, r1 - 1) : r1 - 1;
        w2 = a2 ? alt(2, r2 - 1) : r2 - 1;
        s1 = top(1, w1) - 12;
        s2 = top(2, w2) - 12;
        // Negative request means the largest coefficient the gain limit allows
        if (cf < 0) cf = (2 ** (s1 + s2 + 9)) / (r1 ** 3 * r2 ** 2);
        if (cf > 511) cf = 511;
        ok = r1 <= 32 && r2 <= 64 && r1 ** 3 * r2 ** 2 * cf <= 2 ** (s1 + s2 + 9);
        // Stage state survives writes, so every case starts from reset
        usr_valid = 1'b0;
        rst_n = 1'b0;
        repeat (5) tick();
        rst_n = 1'b1;
        {usr_rate1, usr_rate2, usr_alt1, usr_alt2} = {R1_W'(r1), R2_W'(r2), a1, a2};
        usr_coef = COEF_W'(cf);
        usr_data = IN_W'(x);
        usr_cfg = 1'b1;
        tick();
        usr_cfg = 1'b0;
        check(iq_valid, 1'b1);
        check(cfg_refused, !ok);
        check(cfg_busy, ok);
        if (ok) begin
            for (int i = 0; i < 20 && cfg_busy !== 1'b0; i++) tick();
            check(seen[0][4:0], w1[4:0]);
            check(seen[1][5:0], w2[5:0]);
            check({seen[2][5:0], seen[3][6:0]}, {r1[5:0], r2[6:0]});
            check(usr_ready, 1'b1);
            x1 = (x * cf) >>> 9;
            usr_valid = 1'b1;
            tick();
            check({lnk.smp_valid, lnk.smp_data}, {1'b1, x1[12:0]});
            repeat (12 * r1 * r2 + 40) tick();
            y = (x1 * r1 ** 3) >>> s1;
            e = (y * r2 ** 2) >>> (s2 + 3);
            // A level that outgrows either passed group must lock the chain
            lk = y > 4095 || y < -4096 || e > 511 || e < -512;
            check(iq_data, lk ? 10'h000 : e[9:0]);
            check({iq_valid, ovf_lock}, {lk == 0, lk != 0});
            if (lk) check(lnk.smp_ready, 1'b0);
        end
        $display("test r1=%0d r2=%0d coef=%0d done", r1, r2, cf);
    endtask : run

    initial begin
        {lnk2.cfg_wr, lnk2.cfg_addr, lnk2.cfg_data} = '0;
        {lnk2.smp_valid, lnk2.smp_data} = '0;
        run(4, 4, 1'b0, 1'b0, 511, 1000);
        run(5, 5, 1'b0, 1'b1, 335, -900);
        run(8, 16, 1'b0, 1'b0, 511, -1024);
        run(4, 8, 1'b1, 1'b1, -1, 1023);
        run(5, 5, 1'b0, 1'b0, 168, 700);
        run(33, 4, 1'b0, 1'b0, 1, 5);
        // Path gain within limit, yet stage one outgrows its group
        run(5, 4, 1'b0, 1'b1, 511, 4095);
        for (int i = 0; i < 8; i++) begin
            run(2 + int'(rnd() % 11), 2 + int'(rnd() % 11), rnd() % 2 == 1, rnd() % 2 == 1,
                -1, int'(rnd() % 2048) - 1024);
        end
        // Raw second link: group top at bit 12 with rate 8 must overflow
        rst2_n = 1'b1;
        tick();
        {lnk2.cfg_wr, lnk2.cfg_addr, lnk2.cfg_data} = {1'b1, ADDR_SCALE1, 8'h00};
        tick();
        {lnk2.cfg_addr, lnk2.cfg_data} = {ADDR_RATE1, 8'h08};
        tick();
        lnk2.cfg_wr = 1'b0;
        {lnk2.smp_valid, lnk2.smp_data} = {1'b1, 13'h0FFF};
        for (int i = 0; i < 3000 && lock2 !== 1'b1; i++) tick();
        check(lock2, 1'b1);
        tick();
        check({iqv2, iq2}, '0);
        for (int i = 0; i < 300; i++) begin
            check(lnk2.smp_ready, 1'b0);
            tick();
        end
        rst2_n = 1'b0;
        tick();
        rst2_n = 1'b1;
        tick();
        check(lock2, 1'b0);
        $display("test overflow lock done");
        wrap_up();
    end
endmodule : testbench

/* verilog/cic_chain_dev.sv */
/*
 Two-stage CIC interpolator chain with scale registers and a sticky
 overflow state; the device end of cic_link_if.
 Assumes the feeding party writes the control bus and keeps path gain <= 1.
*/
`timescale 1ns/1ps
module cic_chain_dev
    import cic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    cic_link_if.dev lnk,
    output logic [S2_OUT_W-1:0] iq_data,
    output logic iq_valid,
    output logic ovf_lock
);
    // ============================================================
    // Control registers
    logic [SC1_W-1:0] sc1_q;
    logic [SC1_W-1:0] sc1_d;
    logic [SC2_W-1:0] sc2_q;
    logic [SC2_W-1:0] sc2_d;
    logic [R1_W-1:0] rt1_q;
    logic [R1_W-1:0] rt1_d;
    logic [R2_W-1:0] rt2_q;
    logic [R2_W-1:0] rt2_d;
    logic [R1_W-1:0] wr_r1;
    logic [R2_W-1:0] wr_r2;
    logic restart;

    always_comb begin
        sc1_d = sc1_q;
        sc2_d = sc2_q;
        rt1_d = rt1_q;
        rt2_d = rt2_q;
        restart = 1'b0;
        wr_r1 = lnk.cfg_data[R1_W-1:0];
        wr_r2 = lnk.cfg_data[R2_W-1:0];
        // Out-of-range rates clamp rather than break the divider
        if (wr_r1 == '0) wr_r1 = R1_W'(1);
        if (wr_r1 > R1_MAX) wr_r1 = R1_MAX;
        if (wr_r2 == '0) wr_r2 = R2_W'(1);
        if (wr_r2 > R2_MAX) wr_r2 = R2_MAX;
        if (lnk.cfg_wr) begin
            case (lnk.cfg_addr)
                ADDR_SCALE1: begin
                    sc1_d = lnk.cfg_data[SC1_W-1:0];
                end
                ADDR_SCALE2: begin
                    sc2_d = lnk.cfg_data[SC2_W-1:0];
                end
                ADDR_RATE1: begin
                    rt1_d = wr_r1;
                    restart = 1'b1;
                end
                ADDR_RATE2: begin
                    rt2_d = wr_r2;
                    restart = 1'b1;
                end
                default: begin
                    restart = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sc1_q <= RST_SCALE1;
            sc2_q <= RST_SCALE2;
            rt1_q <= RST_RATE1;
            rt2_q <= RST_RATE2;
        end else begin
            sc1_q <= sc1_d;
            sc2_q <= sc2_d;
            rt1_q <= rt1_d;
            rt2_q <= rt2_d;
        end
    end

    // ============================================================
    // Rate dividers
    // Stage two steps every clock while unlocked; its input rate is clk / R2,
    // and the FIR sample rate is clk / (R1 * R2).
    logic [R1_W-1:0] cnt1_q;
    logic [R1_W-1:0] cnt1_d;
    logic [R2_W-1:0] cnt2_q;
    logic [R2_W-1:0] cnt2_d;
    logic run;
    logic en2;
    logic en1;

    always_comb begin
        run = !ovf_lock;
        en2 = run && (cnt2_q == rt2_q - R2_W'(1));
        en1 = en2 && (cnt1_q == rt1_q - R1_W'(1));
        cnt2_d = cnt2_q;
        cnt1_d = cnt1_q;
        if (restart) begin
            // Rate change mid-stream restarts the phase of both dividers
            cnt2_d = '0;
            cnt1_d = '0;
        end else if (run) begin
            cnt2_d = en2 ? '0 : cnt2_q + R2_W'(1);
            if (en2) cnt1_d = en1 ? '0 : cnt1_q + R1_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt1_q <= '0;
            cnt2_q <= '0;
        end else begin
            cnt1_q <= cnt1_d;
            cnt2_q <= cnt2_d;
        end
    end

    // ============================================================
    // Sample intake
    // A missing sample at the request slot is replaced by zero, so an
    // underrunning feeder costs signal, never rate.
    logic [IN_W-1:0] smp_in;

    assign lnk.smp_ready = en1;
    assign smp_in = lnk.smp_valid ? lnk.smp_data : '0;

    // ============================================================
    // Interpolator stages
    logic [S1_OUT_W-1:0] s1_out;
    logic [S2_OUT_W-1:0] s2_out;
    logic s1_ovf;
    logic s2_ovf;
    logic [MSB_W-1:0] msb_s1;
    logic [MSB_W-1:0] msb_s2;

    assign msb_s1 = msb1(sc1_q);
    assign msb_s2 = msb2(sc2_q);

    cic_stage #(
        .IW(IN_W),
        .AW(S1_ACC_W),
        .OW(S1_OUT_W),
        .ORD(S1_ORDER)
    ) u_stage1 (
        .clk(clk),
        .rst_n(rst_n),
        .in_en(en1),
        .out_en(en2),
        .in_data(smp_in),
        .msb(msb_s1),
        .out_data(s1_out),
        .ovf(s1_ovf)
    );

    cic_stage #(
        .IW(S1_OUT_W),
        .AW(S2_ACC_W),
        .OW(S2_OUT_W),
        .ORD(S2_ORDER)
    ) u_stage2 (
        .clk(clk),
        .rst_n(rst_n),
        .in_en(en2),
        .out_en(run),
        .in_data(s1_out),
        .msb(msb_s2),
        .out_data(s2_out),
        .ovf(s2_ovf)
    );

    // ============================================================
    // Overflow lock and output
    // Only rst_n clears the lock; config writes do not.
    logic ovf_d;
    logic [S2_OUT_W-1:0] iq_d;
    logic valid_d;

    always_comb begin
        ovf_d = ovf_lock | s1_ovf | s2_ovf;
        iq_d = ovf_d ? '0 : s2_out;
        valid_d = !ovf_d;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_lock <= 1'b0;
            iq_data <= '0;
            iq_valid <= 1'b0;
        end else begin
            ovf_lock <= ovf_d;
            iq_data <= iq_d;
            iq_valid <= valid_d;
        end
    end
endmodule : cic_chain_dev

/* verilog/cic_feed_host.sv */
/*
 Feeding and configuring end of cic_link_if: scales user samples by a
 10-bit FIR gain coefficient and programs the chain's scale and rate words.
 Assumes the user holds the configuration inputs while usr_cfg pulses.
*/
`timescale 1ns/1ps
module cic_feed_host
    import cic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    cic_link_if.fir lnk,
    input wire logic usr_cfg,
    input wire logic [R1_W-1:0] usr_rate1,
    input wire logic [R2_W-1:0] usr_rate2,
    input wire logic usr_alt1,
    input wire logic usr_alt2,
    input wire logic [COEF_W-1:0] usr_coef,
    output logic cfg_busy,
    output logic cfg_refused,
    input wire logic usr_valid,
    input wire logic [IN_W-1:0] usr_data,
    output logic usr_ready
);
    // ============================================================
    // Configuration check and write sequence
    typedef enum logic [2:0] {H_IDLE, H_SC1, H_SC2, H_RT1, H_RT2} hst_t;
    hst_t st_q;
    hst_t st_d;
    logic [SC1_W-1:0] sc1;
    logic [SC2_W-1:0] sc2;
    logic [SC2_W-1:0] sc2_q;
    logic [SC2_W-1:0] sc2_d;
    logic [R1_W-1:0] r1_q;
    logic [R1_W-1:0] r1_d;
    logic [R2_W-1:0] r2_q;
    logic [R2_W-1:0] r2_d;
    logic [COEF_W-1:0] coef_q;
    logic [COEF_W-1:0] coef_d;
    logic [COEF_W-1:0] mag;
    logic [GAIN_W-1:0] prod;
    logic [GAIN_W-1:0] lim;
    logic [5:0] sh;
    logic ok;
    logic wr_d;
    logic [ADDR_W-1:0] addr_d;
    logic [DATA_W-1:0] data_d;
    logic ref_d;

    always_comb begin
        sc1 = SC1_W'(usr_rate1 - R1_W'(1));
        sc2 = SC2_W'(usr_rate2 - R2_W'(1));
        if (usr_alt1) sc1 = alt1(sc1);
        if (usr_alt2) sc2 = alt2(sc2);
        mag = usr_coef[COEF_W-1] ? COEF_W'(-usr_coef) : usr_coef;
        // Gain = R1^3 R2^2 coef / 2^(s1 + s2 + 9)
        prod = GAIN_W'(usr_rate1) * GAIN_W'(usr_rate1) * GAIN_W'(usr_rate1)
             * GAIN_W'(usr_rate2) * GAIN_W'(usr_rate2) * GAIN_W'(mag);
        sh = 6'(msb1(sc1) - BASE_MSB) + 6'(msb2(sc2) - BASE_MSB) + 6'(COEF_FRAC);
        lim = GAIN_W'(1) << sh;
        ok = (prod <= lim) && (usr_rate1 != '0) && (usr_rate1 <= R1_MAX)
             && (usr_rate2 != '0) && (usr_rate2 <= R2_MAX);
        st_d = st_q;
        sc2_d = sc2_q;
        r1_d = r1_q;
        r2_d = r2_q;
        coef_d = coef_q;
        wr_d = 1'b0;
        addr_d = lnk.cfg_addr;
        data_d = lnk.cfg_data;
        ref_d = 1'b0;
        case (st_q)
            H_IDLE: begin
                if (usr_cfg && ok) begin
                    sc2_d = sc2;
                    r1_d = usr_rate1;
                    r2_d = usr_rate2;
                    coef_d = usr_coef;
                    st_d = H_SC1;
                    wr_d = 1'b1;
                    addr_d = ADDR_SCALE1;
                    data_d = DATA_W'(sc1);
                end else if (usr_cfg) begin
                    // Over-unity path would lock the chain; refuse it
                    ref_d = 1'b1;
                end
            end
            H_SC1: begin
                st_d = H_SC2;
                wr_d = 1'b1;
                addr_d = ADDR_SCALE2;
                data_d = DATA_W'(sc2_q);
            end
            H_SC2: begin
                st_d = H_RT1;
                wr_d = 1'b1;
                addr_d = ADDR_RATE1;
                data_d = DATA_W'(r1_q);
            end
            H_RT1: begin
                st_d = H_RT2;
                wr_d = 1'b1;
                addr_d = ADDR_RATE2;
                data_d = DATA_W'(r2_q);
            end
            H_RT2: begin
                st_d = H_IDLE;
            end
            default: begin
                st_d = H_IDLE;
            end
        endcase
    end

    assign cfg_busy = (st_q != H_IDLE);

    // ============================================================
    // Sample path
    logic hv_q;
    logic hv_d;
    logic [IN_W-1:0] hold_q;
    logic [IN_W-1:0] hold_d;
    logic signed [IN_W+COEF_W-1:0] mult;

    always_comb begin
        mult = $signed(usr_data) * $signed(coef_q);
        hv_d = hv_q;
        hold_d = hold_q;
        if (lnk.smp_ready && hv_q) hv_d = 1'b0;
        if (usr_valid && usr_ready) begin
            hold_d = mult[COEF_FRAC+IN_W-1:COEF_FRAC];
            hv_d = 1'b1;
        end
    end

    assign usr_ready = !hv_q || lnk.smp_ready;
    assign lnk.smp_valid = hv_q;
    assign lnk.smp_data = hold_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= H_IDLE;
            sc2_q <= RST_SCALE2;
            r1_q <= RST_RATE1;
            r2_q <= RST_RATE2;
            coef_q <= RST_COEF;
            lnk.cfg_wr <= 1'b0;
            lnk.cfg_addr <= '0;
            lnk.cfg_data <= '0;
            cfg_refused <= 1'b0;
            hv_q <= 1'b0;
            hold_q <= '0;
        end else begin
            st_q <= st_d;
            sc2_q <= sc2_d;
            r1_q <= r1_d;
            r2_q <= r2_d;
            coef_q <= coef_d;
            lnk.cfg_wr <= wr_d;
            lnk.cfg_addr <= addr_d;
            lnk.cfg_data <= data_d;
            cfg_refused <= ref_d;
            hv_q <= hv_d;
            hold_q <= hold_d;
        end
    end
endmodule : cic_feed_host

/* verilog/cic_stage.sv */
/*
 One CIC interpolator section with a selectable output bit group.
 Assumes in_en only ever fires on a cycle where out_en also fires.
*/
`timescale 1ns/1ps
module cic_stage
    import cic_pkg::*;
#(
    parameter int IW = 13,
    parameter int AW = 28,
    parameter int OW = 13,
    parameter int ORD = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_en,
    input wire logic out_en,
    input wire logic [IW-1:0] in_data,
    input wire logic [MSB_W-1:0] msb,
    output logic [OW-1:0] out_data,
    output logic ovf
);
    // ============================================================
    // Combs at the low rate, integrators at the high rate
    logic signed [AW-1:0] dly_q [ORD];
    logic signed [AW-1:0] dly_d [ORD];
    logic signed [AW-1:0] itg_q [ORD];
    logic signed [AW-1:0] itg_d [ORD];
    logic signed [AW-1:0] cmb;
    logic signed [AW-1:0] feed;
    logic signed [AW-1:0] hi;
    logic [MSB_W-1:0] sh;
    logic [OW-1:0] out_d;
    logic ovf_d;

    always_comb begin
        cmb = {{(AW-IW){in_data[IW-1]}}, in_data};
        dly_d = dly_q;
        itg_d = itg_q;
        for (int k = 0; k < ORD; k++) begin
            if (in_en) dly_d[k] = cmb;
            cmb = cmb - dly_q[k];
        end
        // Zero stuffing between low-rate samples
        feed = in_en ? cmb : '0;
        if (out_en) begin
            itg_d[0] = itg_q[0] + feed;
            for (int k = 1; k < ORD; k++) begin
                itg_d[k] = itg_q[k] + itg_q[k-1];
            end
        end
        // Group top at msb; gain is R^(ORD-1) over 2^(msb-(OW-1))
        sh = msb - MSB_W'(OW - 1);
        hi = itg_q[ORD-1] >>> msb;
        out_d = out_data;
        ovf_d = 1'b0;
        if (out_en) begin
            out_d = OW'(itg_q[ORD-1] >>> sh);
            // Bits above the group must be pure sign
            ovf_d = (hi != '0) && (hi != '1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < ORD; k++) begin
                dly_q[k] <= '0;
                itg_q[k] <= '0;
            end
            out_data <= '0;
            ovf <= 1'b0;
        end else begin
            dly_q <= dly_d;
            itg_q <= itg_d;
            out_data <= out_d;
            ovf <= ovf_d;
        end
    end
endmodule : cic_stage
